// >>> design/aad_datapath.sv
/*
 * aad_datapath: accumulator, status flags and memory write-back for the
 * add-to-memory and the three AND operations; one request per cycle,
 * results seen at the next clock edge.
 * assumes: the decoder supplies the byte already read from the addressed
 * location together with the request, and the memory takes one write strobe.
 */
`timescale 1ns/1ps
`default_nettype none

module aad_datapath (
    input  wire logic                          i_clk,          // core clock, 40 MHz
    input  wire logic                          i_resetn,       // async reset, active low
    input  wire aad_pkg::aad_req_t             i_req,          // request from the decoder
    input  wire logic                          i_accum_load,   // load from other instructions
    input  wire logic [aad_pkg::DATA_W-1:0]    i_accum_data,   // byte loaded by i_accum_load
    output var  logic [aad_pkg::DATA_W-1:0]    o_accumulator_reg, // accumulator contents
    output var  aad_pkg::aad_flags_t           o_flags,        // status flags
    output var  aad_pkg::aad_mem_wr_t          o_mem_wr        // write toward data memory
);

    logic [aad_pkg::DATA_W-1:0] accumulator_reg_q;  // accumulator
    logic [aad_pkg::DATA_W-1:0] accumulator_reg_d;
    aad_pkg::aad_flags_t        flags_q;            // status flags
    aad_pkg::aad_flags_t        flags_d;
    aad_pkg::aad_mem_wr_t       mem_wr_q;           // registered memory write
    aad_pkg::aad_mem_wr_t       mem_wr_d;

    logic [aad_pkg::DATA_W-1:0] add_sum;            // adder result
    logic                       add_carry;          // adder carry out
    logic                       add_aux;            // adder nibble carry
    logic                       add_ovf;            // adder signed overflow
    logic [aad_pkg::DATA_W-1:0] and_mem;            // accumulator AND memory byte
    logic [aad_pkg::DATA_W-1:0] and_imm;            // accumulator AND immediate

    // shared adder for the add-to-memory operation
    aad_adder u_adder (
        .i_a     (accumulator_reg_q),
        .i_b     (i_req.mem_data),
        .o_sum   (add_sum),
        .o_carry (add_carry),
        .o_aux   (add_aux),
        .o_ovf   (add_ovf)
    );

    assign and_mem = accumulator_reg_q & i_req.mem_data;
    assign and_imm = accumulator_reg_q & i_req.imm;

    // next accumulator, flags and memory write for the current request
    always_comb begin
        accumulator_reg_d = accumulator_reg_q;
        flags_d           = flags_q;
        mem_wr_d          = '{we: 1'b0, addr: mem_wr_q.addr, data: mem_wr_q.data};
        // a plain load from elsewhere in the core; an executing op wins
        if (i_accum_load) begin
            accumulator_reg_d = i_accum_data;
        end
        if (i_req.valid) begin
            unique case (i_req.op)
                aad_pkg::OP_ADD_ACC_TO_MEMORY: begin
                    // sum goes to memory, accumulator keeps its value
                    accumulator_reg_d         = accumulator_reg_q;
                    mem_wr_d                  = '{we: 1'b1, addr: i_req.addr,
                                                  data: add_sum};
                    flags_d.overflow_flag     = add_ovf;
                    flags_d.zero_flag         = (add_sum == aad_pkg::ZERO_BYTE);
                    flags_d.aux_carry_flag    = add_aux;
                    flags_d.carry_flag        = add_carry;
                    // signed carry: sign of the true nine-bit signed sum
                    flags_d.signed_carry_flag = add_sum[aad_pkg::MSB_POS] ^ add_ovf;
                end
                aad_pkg::OP_AND_MEMORY: begin
                    // result to accumulator, only zero changes
                    accumulator_reg_d = and_mem;
                    flags_d.zero_flag = (and_mem == aad_pkg::ZERO_BYTE);
                end
                aad_pkg::OP_AND_IMMEDIATE: begin
                    accumulator_reg_d = and_imm;
                    flags_d.zero_flag = (and_imm == aad_pkg::ZERO_BYTE);
                end
                aad_pkg::OP_AND_ACC_INTO_MEMORY: begin
                    // result to memory, accumulator kept, only zero changes
                    accumulator_reg_d = accumulator_reg_q;
                    mem_wr_d          = '{we: 1'b1, addr: i_req.addr,
                                          data: and_mem};
                    flags_d.zero_flag = (and_mem == aad_pkg::ZERO_BYTE);
                end
                aad_pkg::OP_NOP: begin
                    // nothing to do
                end
                default: begin
                    // unused code: ignored like a nop, so a coinciding load still applies
                end
            endcase
        end
    end

    // registers the state computed above
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            accumulator_reg_q <= aad_pkg::ACCUM_RST;
            flags_q           <= aad_pkg::FLAGS_RST;
            mem_wr_q          <= '{we: 1'b0, addr: aad_pkg::ADDR_RST, data: aad_pkg::ZERO_BYTE};
        end else begin
            accumulator_reg_q <= accumulator_reg_d;
            flags_q           <= flags_d;
            mem_wr_q          <= mem_wr_d;
        end
    end

    assign o_accumulator_reg = accumulator_reg_q;
    assign o_flags           = flags_q;
    assign o_mem_wr          = mem_wr_q;

    // ---- checks -------------------------------------------------------
    logic [aad_pkg::DATA_W:0] chk_sum;   // reference nine-bit sum of last cycle's operands
    logic [aad_pkg::DATA_W:0] chk_sum_q; // registered reference sum

    // reference sum taken at the edge that executes the request, so the
    // properties one edge later see the operands that were really used
    always_ff @(posedge i_clk) begin
        chk_sum_q <= {1'b0, accumulator_reg_q} + {1'b0, i_req.mem_data};
    end

    assign chk_sum = chk_sum_q;

    function automatic logic is_op(input aad_pkg::aad_req_t r, input aad_pkg::aad_op_t o);
        is_op = r.valid && (r.op == o);
    endfunction : is_op

    property p_add_writeback;
        @(posedge i_clk) disable iff (!i_resetn)
        is_op(i_req, aad_pkg::OP_ADD_ACC_TO_MEMORY) |=>
            o_mem_wr.we && (o_mem_wr.addr == $past(i_req.addr))
            && (o_mem_wr.data == chk_sum[aad_pkg::DATA_W-1:0])
            && (o_accumulator_reg == $past(accumulator_reg_q));
    endproperty
    a_add_writeback: assert property (p_add_writeback)
        else $error("add result not written back or accumulator changed");

    property p_add_flags;
        @(posedge i_clk) disable iff (!i_resetn)
        is_op(i_req, aad_pkg::OP_ADD_ACC_TO_MEMORY) |=>
            (o_flags.carry_flag == chk_sum[aad_pkg::DATA_W])
            && (o_flags.zero_flag == (chk_sum[aad_pkg::DATA_W-1:0] == aad_pkg::ZERO_BYTE))
            && (o_flags.overflow_flag ==
                (($past(accumulator_reg_q[aad_pkg::MSB_POS]) == $past(i_req.mem_data[aad_pkg::MSB_POS]))
                 && (chk_sum[aad_pkg::MSB_POS] != $past(accumulator_reg_q[aad_pkg::MSB_POS]))))
            && (o_flags.aux_carry_flag ==
                (($past(accumulator_reg_q[3:0]) + $past(i_req.mem_data[3:0])) > 5'h0F))
            && (o_flags.signed_carry_flag == (chk_sum[aad_pkg::MSB_POS] ^ o_flags.overflow_flag));
    endproperty
    a_add_flags: assert property (p_add_flags)
        else $error("add flags wrong");

    property p_and_mem;
        @(posedge i_clk) disable iff (!i_resetn)
        is_op(i_req, aad_pkg::OP_AND_MEMORY) |=>
            (o_accumulator_reg == ($past(accumulator_reg_q) & $past(i_req.mem_data)))
            && !o_mem_wr.we;
    endproperty
    a_and_mem: assert property (p_and_mem)
        else $error("memory AND result not in accumulator");

    property p_and_imm;
        @(posedge i_clk) disable iff (!i_resetn)
        is_op(i_req, aad_pkg::OP_AND_IMMEDIATE) |=>
            (o_accumulator_reg == ($past(accumulator_reg_q) & $past(i_req.imm)))
            && !o_mem_wr.we;
    endproperty
    a_and_imm: assert property (p_and_imm)
        else $error("immediate AND result not in accumulator");

    property p_and_flags_only_zero;
        @(posedge i_clk) disable iff (!i_resetn)
        (is_op(i_req, aad_pkg::OP_AND_MEMORY) || is_op(i_req, aad_pkg::OP_AND_IMMEDIATE)) |=>
            $stable(o_flags.overflow_flag) && $stable(o_flags.aux_carry_flag)
            && $stable(o_flags.carry_flag) && $stable(o_flags.signed_carry_flag)
            && (o_flags.zero_flag == (o_accumulator_reg == aad_pkg::ZERO_BYTE));
    endproperty
    a_and_flags_only_zero: assert property (p_and_flags_only_zero)
        else $error("AND to accumulator changed a flag other than zero");

    property p_and_into_mem_value;
        @(posedge i_clk) disable iff (!i_resetn)
        is_op(i_req, aad_pkg::OP_AND_ACC_INTO_MEMORY) |=>
            o_mem_wr.we && (o_mem_wr.data == ($past(i_req.mem_data) & $past(accumulator_reg_q)));
    endproperty
    a_and_into_mem_value: assert property (p_and_into_mem_value)
        else $error("AND into memory value wrong");

    property p_and_into_mem_side;
        @(posedge i_clk) disable iff (!i_resetn)
        is_op(i_req, aad_pkg::OP_AND_ACC_INTO_MEMORY) |=>
            (o_mem_wr.addr == $past(i_req.addr))
            && (o_accumulator_reg == $past(accumulator_reg_q))
            && $stable(o_flags.carry_flag) && $stable(o_flags.overflow_flag)
            && (o_flags.zero_flag == (o_mem_wr.data == aad_pkg::ZERO_BYTE))
            ##1 !o_mem_wr.we || $past(i_req.valid);
    endproperty
    a_and_into_mem_side: assert property (p_and_into_mem_side)
        else $error("AND into memory side effects wrong");

    property p_write_only_for_mem_ops;
        @(posedge i_clk) disable iff (!i_resetn)
        o_mem_wr.we |-> ($past(is_op(i_req, aad_pkg::OP_ADD_ACC_TO_MEMORY))
                         || $past(is_op(i_req, aad_pkg::OP_AND_ACC_INTO_MEMORY)));
    endproperty
    a_write_only_for_mem_ops: assert property (p_write_only_for_mem_ops)
        else $error("memory write without a memory-destination op");

    c_add_carry: cover property (@(posedge i_clk) disable iff (!i_resetn)
        is_op(i_req, aad_pkg::OP_ADD_ACC_TO_MEMORY) ##1 o_flags.carry_flag);
    c_and_zero: cover property (@(posedge i_clk) disable iff (!i_resetn)
        is_op(i_req, aad_pkg::OP_AND_IMMEDIATE) ##1 o_flags.zero_flag);
    c_back_to_back: cover property (@(posedge i_clk) disable iff (!i_resetn)
        is_op(i_req, aad_pkg::OP_ADD_ACC_TO_MEMORY)
        ##1 is_op(i_req, aad_pkg::OP_AND_ACC_INTO_MEMORY));

endmodule : aad_datapath

`default_nettype wire

// >>> include/aad_pkg.sv
/*
 * aad_pkg: widths, reset values, bit positions, the operation code, the
 * status flag layout and the request carrier of the accumulator datapath.
 * assumes: the decoder and the data memory run on the same core clock.
 */
// How it works
// - add accumulator to memory, write sum back
// - add updates overflow, zero, aux, carry, signed-carry
// - memory AND accumulator, result into accumulator
// - immediate AND accumulator, result into accumulator
// - accumulator AND ops change only zero flag
// - AND-into-memory computes memory AND accumulator
package aad_pkg;

    localparam int DATA_W   = 8;               // datapath byte width
    localparam int ADDR_W   = 8;               // data memory address width
    localparam int MSB_POS  = 7;               // sign bit position
    localparam int AUX_POS  = 4;               // carry out of the low nibble lands here

    localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;   // accumulator after reset
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;   // all-zero result
    localparam logic [ADDR_W-1:0] ADDR_RST  = 8'h00;   // write address after reset

    // operation asked of the datapath in one cycle
    typedef enum logic [2:0] {
        OP_NOP,
        OP_ADD_ACC_TO_MEMORY,
        OP_AND_MEMORY,
        OP_AND_IMMEDIATE,
        OP_AND_ACC_INTO_MEMORY
    } aad_op_t;

    // status flags kept by the datapath
    typedef struct packed {
        logic overflow_flag;
        logic zero_flag;
        logic aux_carry_flag;
        logic carry_flag;
        logic signed_carry_flag;
    } aad_flags_t;

    localparam aad_flags_t FLAGS_RST = '{default: 1'b0};  // flags after reset

    // one request from the decoder
    typedef struct packed {
        logic              valid;      // request present this cycle
        aad_op_t           op;         // operation to carry out
        logic [ADDR_W-1:0] addr;       // addressed data memory location
        logic [DATA_W-1:0] mem_data;   // byte read from that location
        logic [DATA_W-1:0] imm;        // immediate operand
    } aad_req_t;

    // write toward the data memory
    typedef struct packed {
        logic              we;         // one-cycle write strobe
        logic [ADDR_W-1:0] addr;       // location written
        logic [DATA_W-1:0] data;       // byte written
    } aad_mem_wr_t;

endpackage : aad_pkg

// >>> design/aad_adder.sv
/*
 * aad_adder: combinational 8-bit adder with carry, nibble carry and
 * signed overflow outputs.
 * assumes: operands are stable within the cycle; result is registered outside.
 */
`timescale 1ns/1ps
`default_nettype none

module aad_adder (
    input  wire logic [aad_pkg::DATA_W-1:0] i_a,        // first operand
    input  wire logic [aad_pkg::DATA_W-1:0] i_b,        // second operand
    output var  logic [aad_pkg::DATA_W-1:0] o_sum,      // 8-bit sum
    output var  logic                       o_carry,    // carry out of bit 7
    output var  logic                       o_aux,      // carry out of bit 3
    output var  logic                       o_ovf       // signed overflow
);

    logic [aad_pkg::DATA_W:0]    full_sum;   // sum with carry out
    logic [aad_pkg::AUX_POS:0]   low_sum;    // low nibble sum with its carry
    logic [aad_pkg::MSB_POS:0]   low7_sum;   // low seven bits with carry into sign

    // one sum for the byte, one for the nibble, one for the carry into bit 7
    always_comb begin
        full_sum = {1'b0, i_a} + {1'b0, i_b};
        low_sum  = {1'b0, i_a[aad_pkg::AUX_POS-1:0]} + {1'b0, i_b[aad_pkg::AUX_POS-1:0]};
        low7_sum = {1'b0, i_a[aad_pkg::MSB_POS-1:0]} + {1'b0, i_b[aad_pkg::MSB_POS-1:0]};
        o_sum    = full_sum[aad_pkg::DATA_W-1:0];
        o_carry  = full_sum[aad_pkg::DATA_W];
        o_aux    = low_sum[aad_pkg::AUX_POS];
        // overflow: carry into the sign bit differs from carry out of it
        o_ovf    = low7_sum[aad_pkg::MSB_POS] ^ full_sum[aad_pkg::DATA_W];
    end

endmodule : aad_adder

`default_nettype wire

// >>> dv/test_acc_add_and_datapath.sv
/*
 * test_acc_add_and_datapath: self-checking bench for aad_datapath; a model
 * of the accumulator, flags and memory write is compared at every cycle.
 * assumes: aad_pkg is compiled first; results appear one edge after a request.
 */
`timescale 1ns/1ps
`default_nettype none

module test_acc_add_and_datapath;
    logic                  i_clk;             // core clock, 25 ns period
    logic                  i_resetn;          // async reset, active low
    aad_pkg::aad_req_t     i_req;             // request toward the datapath
    logic                  i_accum_load;      // accumulator load strobe
    logic [7:0]            i_accum_data;      // byte for the load
    logic [7:0]            o_accumulator_reg; // accumulator seen at the port
    aad_pkg::aad_flags_t   o_flags;           // flags seen at the port
    aad_pkg::aad_mem_wr_t  o_mem_wr;          // memory write seen at the port
    logic [7:0]            exp_acc;           // model accumulator
    aad_pkg::aad_flags_t   exp_flags;         // model flags
    aad_pkg::aad_mem_wr_t  exp_mem;           // model memory write
    int                    errors;            // mismatches so far
    int                    check_count;       // comparisons so far
    logic [31:0]           seed;              // random state

    aad_datapath aad_datapath_i (
        .i_clk             (i_clk),
        .i_resetn          (i_resetn),
        .i_req             (i_req),
        .i_accum_load      (i_accum_load),
        .i_accum_data      (i_accum_data),
        .o_accumulator_reg (o_accumulator_reg),
        .o_flags           (o_flags),
        .o_mem_wr          (o_mem_wr)
    );

    // free-running clock
    always #12.5 i_clk = ~i_clk;

    // shift register step for random stimulus
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    // one compare task per result kind
    task automatic cmp_acc(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch acc t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_acc

    task automatic cmp_flags(input aad_pkg::aad_flags_t got, input aad_pkg::aad_flags_t exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch flags t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_flags

    task automatic cmp_mem(input aad_pkg::aad_mem_wr_t got, input aad_pkg::aad_mem_wr_t exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch mem t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_mem

    // model back to its reset state
    task automatic model_reset;
        exp_acc   = 8'h00;
        exp_flags = '0;
        exp_mem   = '0;
    endtask : model_reset

    // compare every output with the model
    task automatic check_all;
        cmp_acc(o_accumulator_reg, exp_acc);
        cmp_flags(o_flags, exp_flags);
        cmp_mem(o_mem_wr, exp_mem);
    endtask : check_all

    // check last result, drive one request at the falling edge, update model
    task automatic apply(input logic v, input logic [2:0] op, input logic [7:0] a,
                         input logic [7:0] m, input logic [7:0] imm,
                         input logic ld, input logic [7:0] ldd);
        int acc0;
        int s;
        logic ov;
        @(negedge i_clk);
        check_all();
        i_req        = '{v, aad_pkg::aad_op_t'(op), a, m, imm};
        i_accum_load = ld;
        i_accum_data = ldd;
        acc0         = exp_acc;
        exp_mem.we   = 1'b0;
        if (ld) exp_acc = ldd;  // load applies unless an op owns the accumulator
        if (v) begin
            case (op)
                3'd1: begin  // add into memory, accumulator kept
                    s         = acc0 + m;
                    ov        = (acc0[7] == m[7]) && (s[7] != acc0[7]);
                    exp_flags = '{ov, (s[7:0] == 0), ((acc0 & 15) + (m & 15)) > 15, s[8],
                                  s[7] ^ ov};
                    exp_mem   = '{1'b1, a, s[7:0]};
                    exp_acc   = acc0[7:0];
                end
                3'd2, 3'd3: begin  // and into accumulator, zero only
                    exp_acc   = acc0[7:0] & ((op == 3'd2) ? m : imm);
                    exp_flags.zero_flag = (exp_acc == 8'h00);
                end
                3'd4: begin  // and into memory, zero only
                    exp_mem   = '{1'b1, a, acc0[7:0] & m};
                    exp_flags.zero_flag = ((acc0[7:0] & m) == 8'h00);
                    exp_acc   = acc0[7:0];
                end
                default: ;  // nop and unused codes change nothing
            endcase
        end
    endtask : apply

    // verdict and end of run
    task automatic wrap_up;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    // watchdog well past the expected run length
    initial begin
        #(25 * 8000);
        errors++;
        wrap_up();
    end

    // corner operand pairs for the adder
    logic [7:0] corner_a [6] = '{8'h80, 8'h7F, 8'h0F, 8'hFF, 8'h00, 8'hC0};
    logic [7:0] corner_m [6] = '{8'h80, 8'h01, 8'h01, 8'h01, 8'h00, 8'h40};

    // main sequence
    initial begin
        i_clk = 1'b0;
        i_resetn = 1'b0;
        i_req = '0;
        i_accum_load = 1'b0;
        i_accum_data = 8'h00;
        errors = 0;
        check_count = 0;
        seed = 32'hE05D;
        model_reset();
        repeat (6) @(posedge i_clk);
        @(negedge i_clk);
        i_resetn = 1'b1;
        // directed corners: op codes 1 to 7 on each pair, each after a load of the pair's accumulator byte
        for (int k = 0; k < 6; k++) begin
            for (int op = 1; op < 8; op++) begin
                apply(1'b0, 3'd0, 8'h00, 8'h00, 8'h00, 1'b1, corner_a[k]);
                apply(1'b1, op[2:0], 8'h10 + k[7:0], corner_m[k], ~corner_a[k], 1'b0, 8'h00);
            end
        end
        // random traffic with a reset in mid-run
        for (int n = 0; n < 3000; n++) begin
            if (n == 1500) begin
                @(negedge i_clk);
                i_resetn = 1'b0;
                // no stale request may be taken at the first edge after release
                i_req = '0;
                i_accum_load = 1'b0;
                #1;
                model_reset();
                check_all();
                @(negedge i_clk);
                i_resetn = 1'b1;
            end
            seed = lfsr(seed);
            apply(seed[31] | seed[30], seed[2:0], seed[10:3], seed[18:11], seed[26:19],
                  seed[29] & seed[28], seed[27:20]);
        end
        apply(1'b0, 3'd0, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00);
        wrap_up();
    end
endmodule : test_acc_add_and_datapath

`default_nettype wire
